/* include/asb_pkg.sv */
// Shared constants and carrier types for the audio stream buffer
package asb_pkg;
	localparam int unsigned BUF_BYTES  = 1024;        // Whole dual-port RAM
	localparam int unsigned PTR_W      = 10;          // Byte address width
	localparam int unsigned CNT_W      = 11;          // Occupancy count width
	localparam int unsigned DATA_W     = 8;           // Byte data port
	localparam int unsigned OTHER_W    = 6;           // Clip and general purpose sources
	localparam logic [CNT_W-1:0] CAP_SINGLE = 11'h400; // One 1 Kbyte buffer
	localparam logic [CNT_W-1:0] CAP_SPLIT  = 11'h200; // Two half-kilobyte buffers
	localparam logic [CNT_W-1:0] PKT_SINGLE = 11'h200; // 512-byte packets
	localparam logic [CNT_W-1:0] PKT_SPLIT  = 11'h100; // 256-byte packets
	localparam logic [PTR_W-1:0] MASK_SINGLE = 10'h3FF;
	localparam logic [PTR_W-1:0] MASK_SPLIT  = 10'h1FF;
	localparam logic [PTR_W-1:0] SPLIT_BASE  = 10'h200; // Second buffer starts here
	localparam logic [PTR_W-1:0] PTR_START   = 10'h000;
	localparam logic [CNT_W-1:0] CNT_EMPTY   = 11'h000;

	// Who owns the external side of the buffer
	typedef enum logic {
		ASB_OWN_CPU = 1'b0,
		ASB_OWN_DFC = 1'b1
	} asb_owner_t;

	// Processor control bits held by software
	typedef struct packed {
		asb_owner_t buffer_access_select;
		logic       buffer_split_mode;
	} asb_ctrl_t;

	// Interrupt enables
	typedef struct packed {
		logic               audio_int_global_enable;
		logic [OTHER_W-1:0] other_int_enable;
		logic               read_ready_int_enable;
		logic               write_request_int_enable;
	} asb_ien_t;

	// One byte access strobe with data
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [DATA_W-1:0] wdata;
	} asb_access_t;
endpackage : asb_pkg

/* hw/asb_tracker.sv */
// Pointer pair and occupancy tracker for one configured buffer
`timescale 1ns/1ps
module asb_tracker (
	input  wire logic                       clk_sys,
	input  wire logic                       nrst,
	input  wire logic                       split,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	input  wire logic                       wr_rst,
	input  wire logic                       rd_rst,
	output logic      [asb_pkg::PTR_W-1:0]  wr_ptr,
	output logic      [asb_pkg::PTR_W-1:0]  rd_ptr,
	output logic      [asb_pkg::CNT_W-1:0]  count,
	output logic                            full,
	output logic                            empty
);
	logic [asb_pkg::PTR_W-1:0] wr_q, wr_d, rd_q, rd_d, mask;
	logic [asb_pkg::CNT_W-1:0] cnt_q, cnt_d, cap;
	logic                      do_wr, do_rd;

	// Next pointers; writes refused when full, reads when empty
	always_comb begin
		mask  = split ? asb_pkg::MASK_SPLIT : asb_pkg::MASK_SINGLE;
		cap   = split ? asb_pkg::CAP_SPLIT : asb_pkg::CAP_SINGLE;
		do_wr = wr_en && (cnt_q != cap);
		do_rd = rd_en && (cnt_q != asb_pkg::CNT_EMPTY);
		wr_d  = do_wr ? ((wr_q + 10'h001) & mask) : wr_q;
		rd_d  = do_rd ? ((rd_q + 10'h001) & mask) : rd_q;
		cnt_d = cnt_q;
		if (do_wr && !do_rd)
			cnt_d = cnt_q + 11'h001;
		else if (do_rd && !do_wr)
			cnt_d = cnt_q - 11'h001;
		// A pointer reset wins over any access in the same cycle
		if (wr_rst)
			wr_d = asb_pkg::PTR_START;
		if (rd_rst)
			rd_d = asb_pkg::PTR_START;
		// Full/empty aliasing is lost on a reset, so occupancy is rebuilt from the distance
		if (wr_rst || rd_rst)
			cnt_d = {1'b0, (wr_d - rd_d) & mask};
	end

	// Empty buffer out of reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_q  <= asb_pkg::PTR_START;
			rd_q  <= asb_pkg::PTR_START;
			cnt_q <= asb_pkg::CNT_EMPTY;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	assign wr_ptr = wr_q;
	assign rd_ptr = rd_q;
	assign count  = cnt_q;
	assign full   = (cnt_q == cap);
	assign empty  = (cnt_q == asb_pkg::CNT_EMPTY);
endmodule : asb_tracker

/* hw/asb_buffer.sv */
// Audio stream buffer: 1 Kbyte dual-port RAM, pointers, packet flags, interrupt request
//
// Notes on behaviour
// - A 1 Kbyte dual-port RAM buffers audio from the DMA controller or CPU.
// - Both CPU and DMA may read and write; the access select bit picks owner.
// - Two DMA channels in split mode, interleaved: one into the processor, one out of it.
// - Split mode gives one or two buffers, each two packets of 512 or 256.
// - Read or write pointer reset bits restart the pointer, then clear themselves.
// - The CPU moves single bytes through the data port; each access not refused when full or empty advances a pointer.
// - Write request flag sets when a packet fits (empty or half); clears when full.
// - Read ready flag sets when a packet is available; clears when buffer empties.
// - Each flag interrupts only while its own interrupt enable is set.
// - Interrupt request asserts whenever any enabled flag is asserted while the global enable is set.
// - A global enable gates the combined interrupt request.
`timescale 1ns/1ps
module asb_buffer (
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	input  wire asb_pkg::asb_ctrl_t            ctrl,
	input  wire asb_pkg::asb_ien_t             ien,
	input  wire logic                          read_pointer_reset_set,
	input  wire logic                          write_pointer_reset_set,
	input  wire asb_pkg::asb_access_t          cpu_acc,
	input  wire asb_pkg::asb_access_t          dfc_acc,
	input  wire asb_pkg::asb_access_t          proc_acc,
	input  wire logic [asb_pkg::OTHER_W-1:0]   other_int_flags,
	output logic      [asb_pkg::DATA_W-1:0]    buffer_data_port,
	output logic      [asb_pkg::DATA_W-1:0]    dfc_rdata,
	output logic      [asb_pkg::DATA_W-1:0]    proc_rdata,
	output logic                               read_pointer_reset,
	output logic                               write_pointer_reset,
	output logic                               write_request_flag,
	output logic                               read_ready_flag,
	output logic                               audio_int_req
);
	// Byte storage, one word per address
	logic [asb_pkg::DATA_W-1:0] mem [asb_pkg::BUF_BYTES];

	logic                      rrst_q, rrst_d, wrst_q, wrst_d;
	logic                      req_q, req_d, rdy_q, rdy_d, irq_q, irq_d;
	logic [asb_pkg::DATA_W-1:0] cpu_rd_q, cpu_rd_d, dfc_rd_q, dfc_rd_d, prc_rd_q, prc_rd_d;
	logic                      split;
	asb_pkg::asb_access_t      ext;
	logic                      in_wr, in_rd, out_wr, out_rd;
	logic [asb_pkg::PTR_W-1:0] in_wp, in_rp, out_wp, out_rp, out_wp_abs, out_rp_abs;
	logic [asb_pkg::CNT_W-1:0] in_cnt, out_cnt, pkt;
	logic                      in_full, in_empty, out_full, out_empty;
	logic [asb_pkg::PTR_W-1:0] t1_wp, t1_rp;
	logic [asb_pkg::CNT_W-1:0] t1_cnt;
	logic                      t1_full, t1_empty;
	logic [asb_pkg::PTR_W-1:0] a_addr, b_addr;
	logic [asb_pkg::OTHER_W+1:0] flags, enables;

	// Owner of the external port: CPU byte port or DMA controller
	always_comb begin
		split = ctrl.buffer_split_mode;
		ext   = (ctrl.buffer_access_select == asb_pkg::ASB_OWN_DFC) ? dfc_acc : cpu_acc;
	end

	// In single mode one buffer serves both directions; split gives each direction its own
	// A write strobe wins over a read on the same port, so no pointer moves for a dropped read
	always_comb begin
		in_wr  = ext.wr || (!split && proc_acc.wr);
		in_rd  = (proc_acc.rd && !proc_acc.wr) || (!split && ext.rd && !ext.wr);
		out_wr = split && proc_acc.wr;
		out_rd = split && ext.rd && !ext.wr;
	end

	// Buffer feeding the processor (whole RAM unless split)
	asb_tracker u_in (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.split   (split),
		.wr_en   (in_wr),
		.rd_en   (in_rd),
		.wr_rst  (wrst_q),
		.rd_rst  (rrst_q),
		.wr_ptr  (in_wp),
		.rd_ptr  (in_rp),
		.count   (in_cnt),
		.full    (in_full),
		.empty   (in_empty)
	);

	// Buffer drained from the processor, upper half in split mode
	asb_tracker u_out (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.split   (1'b1),
		.wr_en   (out_wr),
		.rd_en   (out_rd),
		.wr_rst  (wrst_q),
		.rd_rst  (rrst_q),
		.wr_ptr  (t1_wp),
		.rd_ptr  (t1_rp),
		.count   (t1_cnt),
		.full    (t1_full),
		.empty   (t1_empty)
	);

	// Pick the buffer whose occupancy drives the read side
	always_comb begin
		out_wp     = split ? t1_wp : in_wp;
		out_rp     = split ? t1_rp : in_rp;
		out_cnt    = split ? t1_cnt : in_cnt;
		out_full   = split ? t1_full : in_full;
		out_empty  = split ? t1_empty : in_empty;
		out_wp_abs = split ? (out_wp | asb_pkg::SPLIT_BASE) : out_wp;
		out_rp_abs = split ? (out_rp | asb_pkg::SPLIT_BASE) : out_rp;
		pkt        = split ? asb_pkg::PKT_SPLIT : asb_pkg::PKT_SINGLE;
		// Port A faces CPU or DMA, port B faces the processor
		a_addr     = ext.wr ? in_wp : out_rp_abs;
		b_addr     = proc_acc.wr ? out_wp_abs : in_rp;
	end

	// RAM ports; kept apart from the control idiom because arrays do not reset
	// In single mode both writers share one pointer, so the owner and the processor must take turns
	always_ff @(posedge clk_sys) begin
		if (ext.wr && !in_full)
			mem[a_addr] <= ext.wdata;
		if (proc_acc.wr && !out_full)
			mem[b_addr] <= proc_acc.wdata;
	end

	// Self-clearing pointer reset bits: each stands for the one cycle in which the trackers act
	always_comb begin
		rrst_d = read_pointer_reset_set;
		wrst_d = write_pointer_reset_set;
	end

	// Reset bits read as clear out of reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rrst_q <= 1'b0;
			wrst_q <= 1'b0;
		end else begin
			rrst_q <= rrst_d;
			wrst_q <= wrst_d;
		end
	end

	// Packet flags; setting wins over clearing so a packet's worth of room is never hidden
	always_comb begin
		req_d = req_q;
		if (in_full)
			req_d = 1'b0;
		if (in_cnt <= (split ? asb_pkg::CAP_SPLIT : asb_pkg::CAP_SINGLE) - pkt)
			req_d = 1'b1;                               // Room for a packet wins
		rdy_d = rdy_q;
		if (out_empty)
			rdy_d = 1'b0;
		if (out_cnt >= pkt)
			rdy_d = 1'b1;
	end

	// Flags start low; the first edge after reset raises the request for the empty buffer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			req_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			req_q <= req_d;
			rdy_q <= rdy_d;
		end
	end

	// Read bytes; a refused read keeps the last byte so software sees no phantom data
	always_comb begin
		cpu_rd_d = cpu_rd_q;
		dfc_rd_d = dfc_rd_q;
		prc_rd_d = prc_rd_q;
		if (ext.rd && !out_empty && !ext.wr) begin
			if (ctrl.buffer_access_select == asb_pkg::ASB_OWN_DFC)
				dfc_rd_d = mem[a_addr];
			else
				cpu_rd_d = mem[a_addr];                 // One byte per access
		end
		if (proc_acc.rd && !in_empty && !proc_acc.wr)
			prc_rd_d = mem[b_addr];
	end

	// Read byte registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cpu_rd_q <= '0;
			dfc_rd_q <= '0;
			prc_rd_q <= '0;
		end else begin
			cpu_rd_q <= cpu_rd_d;
			dfc_rd_q <= dfc_rd_d;
			prc_rd_q <= prc_rd_d;
		end
	end

	// Combined interrupt request, registered so the request line never glitches
	always_comb begin
		// Software keeps these enables low under DMA; nothing here enforces it
		flags   = {other_int_flags, rdy_q, req_q};
		enables = {ien.other_int_enable, ien.read_ready_int_enable, ien.write_request_int_enable};
		irq_d   = ien.audio_int_global_enable && |(flags & enables);
	end

	// Interrupt request register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	assign buffer_data_port    = cpu_rd_q;
	assign dfc_rdata           = dfc_rd_q;
	assign proc_rdata          = prc_rd_q;
	assign read_pointer_reset  = rrst_q;
	assign write_pointer_reset = wrst_q;
	assign write_request_flag  = req_q;
	assign read_ready_flag     = rdy_q;
	assign audio_int_req       = irq_q;
endmodule : asb_buffer

/* sim/asb_properties.sv */
// Port checker for the audio stream buffer
`timescale 1ns/1ps
module asb_properties (
	input wire logic                     clk_sys,
	input wire logic                     nrst,
	input wire asb_pkg::asb_ctrl_t       ctrl,
	input wire asb_pkg::asb_ien_t        ien,
	input wire logic                     read_pointer_reset_set,
	input wire logic                     write_pointer_reset_set,
	input wire asb_pkg::asb_access_t     cpu_acc,
	input wire asb_pkg::asb_access_t     dfc_acc,
	input wire asb_pkg::asb_access_t     proc_acc,
	input wire logic [5:0]               other_int_flags,
	input wire logic [7:0]               buffer_data_port,
	input wire logic [7:0]               dfc_rdata,
	input wire logic [7:0]               proc_rdata,
	input wire logic                     read_pointer_reset,
	input wire logic                     write_pointer_reset,
	input wire logic                     write_request_flag,
	input wire logic                     read_ready_flag,
	input wire logic                     audio_int_req
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	rd_bit_set_a:
		assert property (read_pointer_reset_set |=> read_pointer_reset) else $error("read reset bit not set");
	rd_bit_clear_a:
		assert property (read_pointer_reset && !read_pointer_reset_set |=> !read_pointer_reset) else $error("read bit stuck");
	wr_bit_pulse_a:
		assert property (write_pointer_reset_set ##1 !write_pointer_reset_set |-> write_pointer_reset ##1 !write_pointer_reset)
			else $error("write reset bit not a pulse");
	gate_off_a:
		assert property (!ien.audio_int_global_enable |=> !audio_int_req) else $error("irq without global enable");
	req_irq_a:
		assert property (ien.audio_int_global_enable && ien.write_request_int_enable && write_request_flag |=> audio_int_req)
			else $error("write request irq missing");
	rdy_irq_a:
		assert property (ien.audio_int_global_enable && ien.read_ready_int_enable && read_ready_flag |=> audio_int_req)
			else $error("read ready irq missing");
	mask_all_a:
		assert property ((ien[7:0] & {other_int_flags, read_ready_flag, write_request_flag}) == 8'h00 |=> !audio_int_req)
			else $error("irq from masked source");
	cpu_hold_a:
		assert property (!(cpu_acc.rd && ctrl.buffer_access_select == asb_pkg::ASB_OWN_CPU) |=> $stable(buffer_data_port))
			else $error("cpu data moved");
	dfc_hold_a:
		assert property (!(dfc_acc.rd && ctrl.buffer_access_select == asb_pkg::ASB_OWN_DFC) |=> $stable(dfc_rdata))
			else $error("dma data moved");
	proc_hold_a:
		assert property (!proc_acc.rd |=> $stable(proc_rdata)) else $error("processor data moved");
	// Main scenarios reached
	cover property (read_ready_flag && !write_request_flag);
	cover property (audio_int_req);
	cover property (ctrl.buffer_split_mode && read_ready_flag);
endmodule : asb_properties

/* sim/asb_proc_model.sv */
// Behavioural audio processor side: drains the source buffer, fills the destination one
`timescale 1ns/1ps
module asb_proc_model (
	input  wire logic            clk_sys,
	input  wire logic            nrst,
	input  wire logic            run_wr,
	input  wire logic            run_rd,
	output asb_pkg::asb_access_t proc_acc
);
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	logic       slow_q;
	logic       slow_d;
	// Byte counter and half-rate read pacing, so the drain side is slower than the feeder
	always_comb begin
		byte_d = run_wr ? byte_q + 8'h01 : byte_q;
		slow_d = run_rd ? !slow_q : 1'b0;
	end
	// Pacing state
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			byte_q <= 8'h00;
			slow_q <= 1'b0;
		end else begin
			byte_q <= byte_d;
			slow_q <= slow_d;
		end
	end
	// Idle data is inverted so a stale byte never looks valid
	assign proc_acc = '{wr: run_wr, rd: run_rd && slow_q, wdata: run_wr ? byte_q : ~byte_q};
endmodule : asb_proc_model

/* sim/audio_stream_buffer_bench.sv */
// Self-checking bench for the audio stream buffer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module audio_stream_buffer_bench;
	logic                 clk_sys, nrst, rd_ptr_set, wr_ptr_set, p_wr, p_rd;
	asb_pkg::asb_ctrl_t   ctrl;
	asb_pkg::asb_ien_t    ien;
	asb_pkg::asb_access_t cpu_acc, dfc_acc, proc_acc;
	logic [5:0]           other_flags;
	logic [7:0]           cpu_data, dfc_data, proc_data;
	logic                 rd_ptr_bit, wr_ptr_bit, wreq, rrdy, irq;
	int                   mismatches, checks;
	asb_buffer uut (.clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl), .ien(ien), .read_pointer_reset_set(rd_ptr_set),
		.write_pointer_reset_set(wr_ptr_set), .cpu_acc(cpu_acc), .dfc_acc(dfc_acc), .proc_acc(proc_acc),
		.other_int_flags(other_flags), .buffer_data_port(cpu_data), .dfc_rdata(dfc_data), .proc_rdata(proc_data),
		.read_pointer_reset(rd_ptr_bit), .write_pointer_reset(wr_ptr_bit), .write_request_flag(wreq),
		.read_ready_flag(rrdy), .audio_int_req(irq));
	asb_proc_model pm (.clk_sys(clk_sys), .nrst(nrst), .run_wr(p_wr), .run_rd(p_rd), .proc_acc(proc_acc));
	// 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// One byte strobe on the DMA or CPU port as dma picks, owner or not; read data is settled a cycle later
	task automatic ext(input logic dma, input logic wr, input logic [7:0] d);
		if (dma) dfc_acc = '{wr: wr, rd: !wr, wdata: d};
		else cpu_acc = '{wr: wr, rd: !wr, wdata: d};
		tick(1);
		cpu_acc = '{wr: 1'b0, rd: 1'b0, wdata: ~d};
		dfc_acc = '{wr: 1'b0, rd: 1'b0, wdata: ~d};
		tick(1);
	endtask : ext
	task automatic fill(input logic dma, input int n, input int base);
		for (int i = 0; i < n; i++) ext(dma, 1'b1, 8'(base + i));
	endtask : fill
	task automatic drain(input logic dma, input int n, input int base);
		for (int i = 0; i < n; i++) begin
			ext(dma, 1'b0, 8'h00);
			`CHK("rdata", 8'(base + i), dma ? dfc_data : cpu_data)
		end
	endtask : drain
	task automatic flags(input logic w, input logic r);
		tick(2);
		`CHK("wreq", w, wreq)
		`CHK("rrdy", r, rrdy)
	endtask : flags
	task automatic ptr_reset;
		{rd_ptr_set, wr_ptr_set} = 2'b11;
		tick(1);
		{rd_ptr_set, wr_ptr_set} = 2'b00;
		`CHK("ptr bits", 2'b11, {rd_ptr_bit, wr_ptr_bit})
		tick(1);
		`CHK("ptr bits", 2'b00, {rd_ptr_bit, wr_ptr_bit})
	endtask : ptr_reset
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		wrap_up();
	end
	initial begin
		{nrst, rd_ptr_set, wr_ptr_set, p_wr, p_rd, ctrl, ien, cpu_acc, dfc_acc, other_flags, mismatches, checks} = '0;
		tick(16);
		nrst = 1'b1;
		flags(1'b1, 1'b0);
		fill(1'b0, 512, 0);
		flags(1'b1, 1'b1);
		ien = {1'b1, 6'h00, 2'b10};
		tick(2);
		`CHK("irq", 1'b1, irq)
		ien.audio_int_global_enable = 1'b0;
		tick(2);
		`CHK("irq", 1'b0, irq)
		fill(1'b0, 512, 512);
		ext(1'b0, 1'b1, 8'hEE); // Refused while full
		flags(1'b0, 1'b1);
		ien = {1'b1, 6'h01, 2'b01};
		other_flags = 6'h01;
		tick(2);
		`CHK("irq", 1'b1, irq)
		other_flags = 6'h00;
		tick(2);
		`CHK("irq", 1'b0, irq)
		drain(1'b0, 1024, 0);
		flags(1'b1, 1'b0);
		`CHK("irq", 1'b1, irq)
		ext(1'b0, 1'b0, 8'h00); // Refused while empty
		`CHK("cpu data", 8'hFF, cpu_data)
		fill(1'b0, 600, 0);
		ptr_reset();
		flags(1'b1, 1'b0);
		ien = '0;
		ctrl = '{buffer_access_select: asb_pkg::ASB_OWN_DFC, buffer_split_mode: 1'b1};
		ptr_reset();
		fill(1'b1, 256, 8'h40);
		flags(1'b1, 1'b0);
		fill(1'b1, 256, 8'h40);
		flags(1'b0, 1'b0);
		p_wr = 1'b1;
		tick(256);
		p_wr = 1'b0;
		flags(1'b0, 1'b1);
		ext(1'b0, 1'b0, 8'h00); // Not the owner
		`CHK("cpu data", 8'hFF, cpu_data)
		drain(1'b1, 256, 0);
		flags(1'b0, 1'b0);
		p_rd = 1'b1;
		tick(1100);
		p_rd = 1'b0;
		flags(1'b1, 1'b0);
		`CHK("proc data", 8'h3F, proc_data)
		wrap_up();
	end
endmodule : audio_stream_buffer_bench
bind asb_buffer asb_properties chk (.clk_sys, .nrst, .ctrl, .ien, .read_pointer_reset_set, .write_pointer_reset_set,
	.cpu_acc, .dfc_acc, .proc_acc, .other_int_flags, .buffer_data_port, .dfc_rdata, .proc_rdata, .read_pointer_reset,
	.write_pointer_reset, .write_request_flag, .read_ready_flag, .audio_int_req);
